/* dv/rio_field_model.sv */
// Field contact model driving the raw field inputs
module rio_field_model (
  // Clock
  input  wire logic        mclk_i,
  // Contact control
  input  wire logic [15:0] closed_i,
  input  wire logic [15:0] chatter_i,
  // Contact levels
  output logic      [15:0] field_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic flip_reg = 1'b0;

  // Chattering contacts flip level every cycle
  always @(posedge mclk_i)
    flip_reg <= ~flip_reg;

  assign field_o = closed_i ^ (chatter_i & {16{flip_reg}});
endmodule

/* dv/rio_matrix_test.sv */
// Self-checking bench for the relay I/O routing matrix
module rio_matrix_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk_i        = 1'b0;
  logic        rst_n_i       = 1'b0;
  logic [7:0]  addr_i        = 8'h00;
  logic [31:0] wdata_i       = 32'h0;
  logic        wr_i          = 1'b0;
  logic        rd_i          = 1'b0;
  logic [15:0] int_sig_i     = 16'h0;
  logic [7:0]  logic_out_i   = 8'h00;
  logic        release_key_i = 1'b0;
  logic [15:0] closed        = 16'h0;
  logic [15:0] chatter       = 16'h0;
  logic [31:0] rdata_o;
  logic [15:0] field_inputs_i;
  logic [6:0]  trip_outputs_o;
  logic        alarm_output_o;
  logic        service_status_output_o;
  logic [15:0] di_logic_o;
  logic [31:0] d;
  logic [8:0]  outs;
  int          n_mismatch    = 0;
  int          compares      = 0;

  assign outs = {service_status_output_o, alarm_output_o, trip_outputs_o};

  always #5 mclk_i = ~mclk_i;

  rio_matrix #(.TICK_CYCLES(4)) dut (
    .mclk_i                  (mclk_i),
    .rst_n_i                 (rst_n_i),
    .addr_i                  (addr_i),
    .wdata_i                 (wdata_i),
    .wr_i                    (wr_i),
    .rd_i                    (rd_i),
    .rdata_o                 (rdata_o),
    .int_sig_i               (int_sig_i),
    .logic_out_i             (logic_out_i),
    .field_inputs_i          (field_inputs_i),
    .release_key_i           (release_key_i),
    .trip_outputs_o          (trip_outputs_o),
    .alarm_output_o          (alarm_output_o),
    .service_status_output_o (service_status_output_o),
    .di_logic_o              (di_logic_o)
  );

  rio_field_model model (
    .mclk_i    (mclk_i),
    .closed_i  (closed),
    .chatter_i (chatter),
    .field_o   (field_inputs_i)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic xsel(input logic [5:0] s, input logic [3:0] o);
    wr(rio_pkg::OFS_XSEL, {18'h0, s, 4'h0, o});
  endtask

  task automatic end_sim;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4000) @(posedge mclk_i);
    n_mismatch++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // Reset values and unmapped place
    rd(rio_pkg::OFS_CTRL);    chk("ctrl", 32'h0, d);
    rd(rio_pkg::OFS_OUT_POL); chk("opol", 32'h0, d);
    rd(rio_pkg::OFS_DI_POL);  chk("dipol", 32'h0, d);
    rd(8'h3c);                chk("unmapped", 32'h0, d);
    wr(8'h44, 32'h1fff);
    rd(8'h44);                chk("dly_clamp", 32'h1770, d);
    // Crossing steps through its three states
    for (int i = 1; i <= 3; i++)
    begin
      xsel(6'h00, 4'h0);
      wr(rio_pkg::OFS_ROW_SEL, 32'h0);
      rd(rio_pkg::OFS_ROW_DATA);
      chk("xing", 32'(i % 3), {30'h0, d[1:0]});
    end
    // Connected source and polarity
    xsel(6'h00, 4'h0);
    @(posedge mclk_i);
    int_sig_i[0] <= 1'b1;
    wt(2);
    chk("conn", 32'h001, {23'h0, outs});
    wr(rio_pkg::OFS_OUT_POL, 32'h1);
    wt(2);
    chk("pol", 32'h000, {23'h0, outs});
    @(posedge mclk_i);
    int_sig_i[0] <= 1'b0;
    wt(2);
    chk("pol_idle", 32'h001, {23'h0, outs});
    wr(rio_pkg::OFS_OUT_POL, 32'h0);
    // Latched alarm released by key, then by command
    xsel(6'h01, 4'h7);
    xsel(6'h01, 4'h7);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk_i);
      int_sig_i[1] <= 1'b1;
      @(posedge mclk_i);
      int_sig_i[1] <= 1'b0;
      wt(4);
      chk("latch", 32'h080, {23'h0, outs});
      rd(rio_pkg::OFS_LATCH);
      chk("latch_bits", 32'h080, d);
      if (k == 0)
      begin
        @(posedge mclk_i);
        release_key_i <= 1'b1;
        @(posedge mclk_i);
        release_key_i <= 1'b0;
      end
      else
        wr(rio_pkg::OFS_CTRL, 32'h2);
      wt(3);
      chk("release", 32'h000, {23'h0, outs});
    end
    // Logic output row without assignment step
    xsel(6'h20, 4'h8);
    @(posedge mclk_i);
    logic_out_i[0] <= 1'b1;
    wt(2);
    chk("logic_row", 32'h100, {23'h0, outs});
    // Forcing refused while off, taken while on
    wr(rio_pkg::OFS_OUT_STAT, 32'h1ff);
    wt(2);
    rd(rio_pkg::OFS_OUT_STAT);
    chk("force_off", 32'h100, d);
    wr(rio_pkg::OFS_CTRL, 32'h1);
    wr(rio_pkg::OFS_OUT_STAT, 32'h055);
    wt(2);
    chk("forced", 32'h055, {23'h0, outs});
    rd(rio_pkg::OFS_OUT_STAT);
    chk("forced_stat", 32'h055, d);
    wr(rio_pkg::OFS_CTRL, 32'h0);
    wt(2);
    chk("unforced", 32'h100, {23'h0, outs});
    // Qualified field input with two delay units
    wr(8'h40, 32'h2);
    xsel(6'h10, 4'h1);
    @(posedge mclk_i);
    closed[0] <= 1'b1;
    wt(4);
    chk("di_early", 32'h0, {31'h0, trip_outputs_o[1]});
    wt(16);
    chk("di_route", 32'h1, {31'h0, trip_outputs_o[1]});
    rd(rio_pkg::OFS_DI_STATE);
    chk("di_state", 32'h1, {31'h0, d[0]});
    @(posedge mclk_i);
    closed[0]  <= 1'b0;
    chatter[0] <= 1'b1;
    wt(30);
    chk("di_chatter", 32'h1, {31'h0, trip_outputs_o[1]});
    @(posedge mclk_i);
    chatter[0] <= 1'b0;
    wt(20);
    chk("di_off", 32'h0, {31'h0, trip_outputs_o[1]});
    // Latched field input route
    xsel(6'h10, 4'h1);
    closed[0] <= 1'b1;
    wt(20);
    chk("di_lroute", 32'h1, {31'h0, trip_outputs_o[1]});
    @(posedge mclk_i);
    closed[0] <= 1'b0;
    wt(20);
    chk("di_lhold", 32'h1, {31'h0, trip_outputs_o[1]});
    // Normally closed input sixteen toward logic
    wr(rio_pkg::OFS_DI_POL, 32'h8000);
    wt(3);
    chk("di_nc", 32'h1, {31'h0, di_logic_o[15]});
    // Latched input toward logic
    wr(rio_pkg::OFS_DI_LATEN, 32'h4000);
    closed[14] <= 1'b1;
    wt(3);
    @(posedge mclk_i);
    closed[14] <= 1'b0;
    wt(5);
    chk("di_latch", 32'h1, {31'h0, di_logic_o[14]});
    @(posedge mclk_i);
    release_key_i <= 1'b1;
    @(posedge mclk_i);
    release_key_i <= 1'b0;
    wt(4);
    chk("di_unlatch", 32'h0, {31'h0, di_logic_o[14]});
    chk("di_lfree", 32'h0, {31'h0, trip_outputs_o[1]});
    end_sim();
  end
endmodule

/* include/rio_pkg.sv */
// Constants and types for the relay I/O routing matrix
// How it works
// - Each output has a polarity bit; reverse inverts the driven position.
// - Any source can drive any output, latched or not.
// - A crossing steps open, connected, latched, open on each select.
// - Latched outputs hold until the enter key or a release write.
// - A force flag enables test forcing; forced writes refused while off.
// - Output positions read as status bits, writable only while forcing.
// - Logic function outputs are crossbar rows with no assignment step.
// - Each field input has NO/NC polarity and a qualifying delay.
// - Qualified field inputs are crossbar rows, latched or not.
// - Field inputs feed logic operators directly, optionally latched.
// - Up to sixteen field inputs, each with state, polarity, delay.
// - Input changes only after the raw level is stable for the delay.
package rio_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_TRIP  = 7;
  localparam int NUM_OUT   = 9;
  localparam int NUM_DI    = 16;
  localparam int NUM_INT   = 16;
  localparam int NUM_LOGIC = 8;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int DLY_W     = 13;
  localparam int SRC_W     = 6;
  localparam int OUTI_W    = 4;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_OUT_POL  = 8'h04;
  localparam logic [7:0] OFS_OUT_STAT = 8'h08;
  localparam logic [7:0] OFS_DI_POL   = 8'h0c;
  localparam logic [7:0] OFS_DI_STATE = 8'h10;
  localparam logic [7:0] OFS_LATCH    = 8'h14;
  localparam logic [7:0] OFS_XSEL     = 8'h18;
  localparam logic [7:0] OFS_ROW_SEL  = 8'h1c;
  localparam logic [7:0] OFS_ROW_DATA = 8'h20;
  localparam logic [7:0] OFS_DI_LATEN = 8'h24;
  localparam logic [1:0] DLY_PAGE     = 2'h1;
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_REL_BIT   = 1;
  localparam int XSEL_OUT_LSB   = 0;
  localparam int XSEL_SRC_LSB   = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic              FORCE_RST = 1'b0;
  localparam logic [NUM_OUT-1:0] OPOL_RST = 9'h000;
  localparam logic [NUM_DI-1:0] DIPOL_RST = 16'h0000;
  localparam logic [DLY_W-1:0]  DLY_RST   = 13'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DLY_UNIT_NS   = 10_000_000;
  localparam int TICK_CYCLES   = DLY_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [DLY_W-1:0] DLY_MAX = 13'h1770;

  // ----------------------------------------------------------------
  // Crossing states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {X_OPEN, X_CONN, X_LATCH} rio_xing_t;

endpackage

/* verilog/rio_di_qual.sv */
// Field input qualifier with equal on and off delay
module rio_di_qual #(
  parameter int DLY_W = rio_pkg::DLY_W
) (
  // Clock and reset
  input  logic             mclk_i,
  input  logic             rst_n_i,
  // Control
  input  logic             tick_i,
  input  logic [DLY_W-1:0] delay_i,
  // Level
  input  logic             raw_i,
  output logic             state_o
);

  logic [DLY_W-1:0] cnt_reg;
  logic             state_reg;

  // ----------------------------------------------------------------
  // Stability timer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg   <= '0;
      state_reg <= 1'b0;
    end
    else if (raw_i == state_reg)
    begin
      cnt_reg <= '0;
    end
    else if (cnt_reg >= delay_i)
    begin
      state_reg <= raw_i;
      cnt_reg   <= '0;
    end
    else if (tick_i)
    begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign state_o = state_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_toward_raw;
    @(posedge mclk_i) disable iff (!rst_n_i)
    $changed(state_reg) |-> $past(raw_i) == state_reg;
  endproperty
  a_toward_raw: assert property (p_toward_raw)
    else $error("input state moved away from raw level");

  property p_zero_delay;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (delay_i == '0 && raw_i != state_reg) |=> state_reg == $past(raw_i);
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("zero delay input did not follow raw level");

  property p_wait;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (raw_i != state_reg && cnt_reg < delay_i) |=> $stable(state_reg);
  endproperty
  a_wait: assert property (p_wait)
    else $error("input state changed before delay ran out");

endmodule

/* verilog/rio_matrix.sv */
// Relay I/O routing matrix with output forcing and input qualification
//
// The placing of the registers and the plain strobed port were left to the implementer.
module rio_matrix #(
  parameter int NUM_INT     = rio_pkg::NUM_INT,
  parameter int NUM_DI      = rio_pkg::NUM_DI,
  parameter int NUM_LOGIC   = rio_pkg::NUM_LOGIC,
  parameter int TICK_CYCLES = rio_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  logic                         mclk_i,
  input  logic                         rst_n_i,
  // Register port
  input  logic [rio_pkg::ADDR_W-1:0]   addr_i,
  input  logic [rio_pkg::DATA_W-1:0]   wdata_i,
  input  logic                         wr_i,
  input  logic                         rd_i,
  output logic [rio_pkg::DATA_W-1:0]   rdata_o,
  // Signal sources
  input  logic [NUM_INT-1:0]           int_sig_i,
  input  logic [NUM_LOGIC-1:0]         logic_out_i,
  input  logic [NUM_DI-1:0]            field_inputs_i,
  input  logic                         release_key_i,
  // Output contacts
  output logic [rio_pkg::NUM_TRIP-1:0] trip_outputs_o,
  output logic                         alarm_output_o,
  output logic                         service_status_output_o,
  // Field inputs toward logic operators
  output logic [NUM_DI-1:0]            di_logic_o
);

  localparam int NUM_SRC = NUM_INT + NUM_DI + NUM_LOGIC;
  localparam int NO      = rio_pkg::NUM_OUT;
  localparam int DW      = rio_pkg::DLY_W;
  localparam int TCW     = $clog2(TICK_CYCLES + 1);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic rio_pkg::rio_xing_t xing_step(
    input rio_pkg::rio_xing_t s);
    case (s)
      rio_pkg::X_OPEN: xing_step = rio_pkg::X_CONN;
      rio_pkg::X_CONN: xing_step = rio_pkg::X_LATCH;
      default:         xing_step = rio_pkg::X_OPEN;
    endcase
  endfunction

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_i && (addr_i == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rio_pkg::rio_xing_t            xing_reg [NUM_SRC][NO];
  logic                          force_reg;
  logic [NO-1:0]                 opol_reg;
  logic [NO-1:0]                 fval_reg;
  logic [NO-1:0]                 out_reg;
  logic [NO-1:0]                 latch_reg;
  logic [NUM_DI-1:0]             dipol_reg;
  logic [NUM_DI-1:0]             dilen_reg;
  logic [NUM_DI-1:0]             dilatch_reg;
  logic [NUM_DI-1:0]             di_logic_reg;
  logic [DW-1:0]                 dly_reg [NUM_DI];
  logic [rio_pkg::SRC_W-1:0]     row_reg;
  logic [rio_pkg::DATA_W-1:0]    rdata_reg;
  logic [rio_pkg::DATA_W-1:0]    rd_mux;
  logic [TCW-1:0]                tick_cnt_reg;
  logic                          tick_reg;
  logic [NUM_DI-1:0]             di_qual;
  logic [NUM_DI-1:0]             di_state;
  logic [NUM_SRC-1:0]            src;
  logic [NO-1:0]                 direct;
  logic [NO-1:0]                 lset;
  logic [NO-1:0]                 routed;
  logic                          release_req;
  logic [rio_pkg::SRC_W-1:0]     xs_src;
  logic [rio_pkg::OUTI_W-1:0]    xs_out;
  logic                          xs_ok;
  logic                          wr_dly;
  logic [3:0]                    dly_idx;
  logic [DW-1:0]                 dly_wval;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign xs_src  = wdata_i[rio_pkg::XSEL_SRC_LSB +: rio_pkg::SRC_W];
  assign xs_out  = wdata_i[rio_pkg::XSEL_OUT_LSB +: rio_pkg::OUTI_W];
  assign xs_ok   = (int'(xs_src) < NUM_SRC) && (int'(xs_out) < NO);
  assign dly_idx = addr_i[5:2];
  assign wr_dly  = wr_i && (addr_i[7:6] == rio_pkg::DLY_PAGE) &&
                   (addr_i[1:0] == 2'h0) && (int'(dly_idx) < NUM_DI);
  assign dly_wval = (wdata_i[DW-1:0] > rio_pkg::DLY_MAX) ?
                    rio_pkg::DLY_MAX : wdata_i[DW-1:0];
  assign release_req = release_key_i ||
    (wr_at(rio_pkg::OFS_CTRL) && wdata_i[rio_pkg::CTRL_REL_BIT]);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      force_reg <= rio_pkg::FORCE_RST;
      opol_reg  <= rio_pkg::OPOL_RST;
      dipol_reg <= rio_pkg::DIPOL_RST;
      dilen_reg <= '0;
      row_reg   <= '0;
    end
    else
    begin
      if (wr_at(rio_pkg::OFS_CTRL))
        force_reg <= wdata_i[rio_pkg::CTRL_FORCE_BIT];
      if (wr_at(rio_pkg::OFS_OUT_POL))
        opol_reg <= wdata_i[NO-1:0];
      if (wr_at(rio_pkg::OFS_DI_POL))
        dipol_reg <= wdata_i[NUM_DI-1:0];
      if (wr_at(rio_pkg::OFS_DI_LATEN))
        dilen_reg <= wdata_i[NUM_DI-1:0];
      if (wr_at(rio_pkg::OFS_ROW_SEL))
        row_reg <= wdata_i[rio_pkg::SRC_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < NUM_DI; i++)
        dly_reg[i] <= rio_pkg::DLY_RST;
    end
    else if (wr_dly)
    begin
      dly_reg[dly_idx] <= dly_wval;
    end
  end

  // ----------------------------------------------------------------
  // Crossbar cells
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int s = 0; s < NUM_SRC; s++)
        for (int o = 0; o < NO; o++)
          xing_reg[s][o] <= rio_pkg::X_OPEN;
    end
    else if (wr_at(rio_pkg::OFS_XSEL) && xs_ok)
    begin
      xing_reg[xs_src][xs_out] <= xing_step(xing_reg[xs_src][xs_out]);
    end
  end

  // ----------------------------------------------------------------
  // Delay tick divider
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == TCW'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Field input qualification
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_DI; i++)
  begin : g_di
    rio_di_qual #(
      .DLY_W   (DW)
    ) u_qual (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .tick_i  (tick_reg),
      .delay_i (dly_reg[i]),
      .raw_i   (field_inputs_i[i]),
      .state_o (di_qual[i])
    );
  end

  assign di_state = di_qual ^ dipol_reg;

  // Sources: internal, then field inputs, then logic outputs
  assign src = {logic_out_i, di_state, int_sig_i};

  // ----------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------
  always_comb
  begin
    direct = '0;
    lset   = '0;
    for (int o = 0; o < NO; o++)
    begin
      for (int s = 0; s < NUM_SRC; s++)
      begin
        if (src[s] && xing_reg[s][o] == rio_pkg::X_CONN)
          direct[o] = 1'b1;
        if (src[s] && xing_reg[s][o] == rio_pkg::X_LATCH)
          lset[o] = 1'b1;
      end
    end
  end

  assign routed = direct | lset | latch_reg;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      latch_reg <= '0;
    else
      latch_reg <= (latch_reg & ~{NO{release_req}}) | lset;
  end

  // ----------------------------------------------------------------
  // Forcing and output drive
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fval_reg <= '0;
    else if (!force_reg)
      fval_reg <= routed ^ opol_reg;
    else if (wr_at(rio_pkg::OFS_OUT_STAT))
      fval_reg <= wdata_i[NO-1:0];
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      out_reg <= '0;
    else if (force_reg)
      out_reg <= fval_reg;
    else
      out_reg <= routed ^ opol_reg;
  end

  assign trip_outputs_o          = out_reg[rio_pkg::NUM_TRIP-1:0];
  assign alarm_output_o          = out_reg[rio_pkg::NUM_TRIP];
  assign service_status_output_o = out_reg[rio_pkg::NUM_TRIP+1];

  // ----------------------------------------------------------------
  // Field inputs toward logic
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dilatch_reg  <= '0;
      di_logic_reg <= '0;
    end
    else
    begin
      dilatch_reg <= (dilatch_reg & ~{NUM_DI{release_req}}) |
                     (di_state & dilen_reg);
      di_logic_reg <= di_state | (dilatch_reg & dilen_reg);
    end
  end

  assign di_logic_o = di_logic_reg;

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = '0;
    case (addr_i)
      rio_pkg::OFS_CTRL:     rd_mux[rio_pkg::CTRL_FORCE_BIT] = force_reg;
      rio_pkg::OFS_OUT_POL:  rd_mux[NO-1:0] = opol_reg;
      rio_pkg::OFS_OUT_STAT: rd_mux[NO-1:0] = out_reg;
      rio_pkg::OFS_DI_POL:   rd_mux[NUM_DI-1:0] = dipol_reg;
      rio_pkg::OFS_DI_STATE: rd_mux[NUM_DI-1:0] = di_state;
      rio_pkg::OFS_LATCH:    rd_mux[NO-1:0] = latch_reg;
      rio_pkg::OFS_ROW_SEL:  rd_mux[rio_pkg::SRC_W-1:0] = row_reg;
      rio_pkg::OFS_DI_LATEN: rd_mux[NUM_DI-1:0] = dilen_reg;
      rio_pkg::OFS_ROW_DATA:
      begin
        if (int'(row_reg) < NUM_SRC)
          for (int o = 0; o < NO; o++)
            rd_mux[2*o +: 2] = xing_reg[row_reg][o];
      end
      default:
      begin
        if (addr_i[7:6] == rio_pkg::DLY_PAGE && addr_i[1:0] == 2'h0 &&
            int'(dly_idx) < NUM_DI)
          rd_mux[DW-1:0] = dly_reg[dly_idx];
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_reg <= '0;
    else if (rd_i)
      rdata_reg <= rd_mux;
    else
      rdata_reg <= '0;
  end

  assign rdata_o = rdata_reg;

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------
  logic                      h_vld;
  logic [rio_pkg::SRC_W-1:0] h_src;
  logic [rio_pkg::OUTI_W-1:0] h_out;
  rio_pkg::rio_xing_t        h_prev;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      h_vld  <= 1'b0;
      h_src  <= '0;
      h_out  <= '0;
      h_prev <= rio_pkg::X_OPEN;
    end
    else
    begin
      h_vld <= wr_at(rio_pkg::OFS_XSEL) && xs_ok;
      if (wr_at(rio_pkg::OFS_XSEL) && xs_ok)
      begin
        h_src  <= xs_src;
        h_out  <= xs_out;
        h_prev <= xing_reg[xs_src][xs_out];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pol_idle;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!force_reg && routed == '0) |=> out_reg == $past(opol_reg);
  endproperty
  a_pol_idle: assert property (p_pol_idle)
    else $error("idle output position does not match polarity");

  property p_step;
    @(posedge mclk_i) disable iff (!rst_n_i)
    h_vld |-> xing_reg[h_src][h_out] == xing_step(h_prev);
  endproperty
  a_step: assert property (p_step)
    else $error("crossing did not advance one step");

  property p_latch_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !release_req |=> (latch_reg & $past(latch_reg)) == $past(latch_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch dropped without release");

  property p_release;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (release_req && lset == '0) |=> latch_reg == '0;
  endproperty
  a_release: assert property (p_release)
    else $error("release did not clear latches");

  property p_force_refused;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == rio_pkg::OFS_OUT_STAT && !force_reg)
      |=> fval_reg == $past(routed ^ opol_reg);
  endproperty
  a_force_refused: assert property (p_force_refused)
    else $error("forced value written while force flag off");

  property p_force_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (force_reg && wr_i && addr_i == rio_pkg::OFS_OUT_STAT) ##1 force_reg
      |=> out_reg == $past(wdata_i[NO-1:0], 2);
  endproperty
  a_force_write: assert property (p_force_write)
    else $error("forced output value not driven");

  property p_logic_src;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!force_reg && logic_out_i[0] &&
     xing_reg[NUM_INT+NUM_DI][NO-1] == rio_pkg::X_CONN)
      |=> out_reg[NO-1] == !$past(opol_reg[NO-1]);
  endproperty
  a_logic_src: assert property (p_logic_src)
    else $error("logic output did not reach its contact");

  property p_di_latch;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (di_state[0] && xing_reg[NUM_INT][1] == rio_pkg::X_LATCH)
      |=> latch_reg[1];
  endproperty
  a_di_latch: assert property (p_di_latch)
    else $error("field input did not set its output latch");

  property p_di_logic;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (dilen_reg[NUM_DI-2] && dilatch_reg[NUM_DI-2] && !release_req &&
     !(wr_i && addr_i == rio_pkg::OFS_DI_LATEN))
      |=> di_logic_o[NUM_DI-2] [*2];
  endproperty
  a_di_logic: assert property (p_di_logic)
    else $error("latched field input dropped toward logic");

endmodule
